// ### core/spfc_ctrl.sv
// Purpose: spin-up gating, fast format decode and block size control
// Assumes: one 200 MHz clock, asynchronous active-low reset, APB slave
// Notes: the tick length is a parameter so that a bench can shorten every time limit
// Notes on behaviour
// - fast format field value one requests a fast format
// - field values two or three end with check condition 05/24
// - fast format conversion allowed only when sizes differ by exact factor eight; the code also allows it when both sizes are equal
// - new block size stays pending until a format completes
// - resets to emulated small block format; sizes checked per configuration
// - format time runs from last command byte to status request; OFF_FMT shows time_q, which a format command does not clear
// - commands accepted within three seconds after power-on
// - enable primitive without earlier stop gives ready within 30 seconds; without spin-done the code waits 35 s, READY_TICKS plus EXTRA_TICKS
// - stop before primitive needs start then primitive, then 30 seconds; the code times out at 35 s there too
// - start with immediate fails when no primitive within five seconds
// - stop with immediate clear returns status only after spindle stops
// - spindle stop completes within 23 seconds
// - power loss or temperature extremes may add five seconds
// - prefetch and caching controlled by separate bits
// - read ahead disable bit one turns prefetch off
`timescale 1ns/10ps
`default_nettype none

module spfc_ctrl
  import spfc_pkg::*;
#(
  // pclk cycles per timing tick
  parameter int unsigned TICK_CYCLES = TICK_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // enable-spinup primitives from the two ports
  input wire logic spinup_port0,
  input wire logic spinup_port1,
  // device status outputs
  output logic unit_ready,
  output logic cmd_accept,
  output logic spindle_on,
  output logic prefetch_en,
  output logic cache_en,
  output logic irq
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] sp0_meta_q, sp0_sync_q, sp1_meta_q, sp1_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp0_meta_q <= 2'h0;
      sp0_sync_q <= 2'h0;
      sp1_meta_q <= 2'h0;
      sp1_sync_q <= 2'h0;
    end else begin
      sp0_meta_q <= {sp0_meta_q[0], spinup_port0};
      sp1_meta_q <= {sp1_meta_q[0], spinup_port1};
      sp0_sync_q <= {sp0_sync_q[0], sp0_meta_q[1]};
      sp1_sync_q <= {sp1_sync_q[0], sp1_meta_q[1]};
    end
  end
  logic spinup_ev;
  assign spinup_ev = (sp0_sync_q[0] & ~sp0_sync_q[1]) | (sp1_sync_q[0] & ~sp1_sync_q[1]);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic wr_en;
  logic rd_hit;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  always_comb begin
    unique case (paddr)
      OFF_CTRL, OFF_STAT, OFF_CMD, OFF_FMT, OFF_BLK, OFF_CACHE,
      OFF_IRQ_ST, OFF_IRQ_MSK, OFF_SENSE: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~rd_hit;

  // ****************************************************************
  // tick counter
  // ****************************************************************
  logic [17:0] div_q;
  logic tick;
  logic [15:0] time_q;
  logic time_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 18'h0;
    end else if (div_q == 18'(TICK_CYCLES - 1)) begin
      div_q <= 18'h0;
    end else begin
      div_q <= div_q + 18'h1;
    end
  end
  assign tick = (div_q == 18'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_q <= 16'h0;
    end else if (time_clr) begin
      time_q <= 16'h0;
    end else if (tick && time_q != 16'hffff) begin
      time_q <= time_q + 16'h1;
    end
  end

  logic [15:0] pon_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pon_q <= 16'h0;
    end else if (tick && pon_q != 16'(ACCEPT_TICKS - 1)) begin
      pon_q <= pon_q + 16'h1;
    end
  end
  assign cmd_accept = (pon_q == 16'(ACCEPT_TICKS - 1));

  // ****************************************************************
  // start-stop command capture
  // ****************************************************************
  spfc_ss_s ss;
  logic ctrl_native_q, spin_done_q, stop_done_q;
  assign ss.valid = wr_en && paddr == OFF_CMD && pwdata[CMD_SS] && cmd_accept;
  assign ss.start = pwdata[CMD_START];
  assign ss.immediate_return_flag = pwdata[CMD_IMMEDIATE_RETURN_FLAG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_native_q <= 1'b0;
      spin_done_q <= 1'b0;
      stop_done_q <= 1'b0;
    end else begin
      spin_done_q <= wr_en && paddr == OFF_CTRL && pwdata[CTRL_SPIN_DONE];
      stop_done_q <= wr_en && paddr == OFF_CTRL && pwdata[CTRL_STOP_DONE];
      if (wr_en && paddr == OFF_CTRL) begin
        ctrl_native_q <= pwdata[CTRL_NATIVE];
      end
    end
  end

  // ****************************************************************
  // spin-up state machine
  // ****************************************************************
  spfc_spin_e st_q;
  logic stop_first_q, seen_en_q, imm_wait_q;
  logic ev_ready, ev_fail, ev_stopped;
  assign time_clr = ss.valid || (spinup_ev && (st_q == SPFC_SP_IDLE || st_q == SPFC_SP_WAIT_EN));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_first_q <= 1'b0;
      seen_en_q <= 1'b0;
    end else begin
      if (spinup_ev) begin
        seen_en_q <= 1'b1;
      end
      if (ss.valid && !ss.start && !seen_en_q) begin
        stop_first_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SPFC_SP_IDLE;
      imm_wait_q <= 1'b0;
    end else begin
      unique case (st_q)
        SPFC_SP_IDLE: begin
          if (ss.valid && !ss.start) begin
            st_q <= SPFC_SP_WAIT_START;
          end else if (spinup_ev) begin
            st_q <= SPFC_SP_SPIN;
          end
        end
        SPFC_SP_WAIT_START: begin
          if (ss.valid && ss.start) begin
            st_q <= SPFC_SP_WAIT_EN;
            imm_wait_q <= ss.immediate_return_flag;
          end
        end
        SPFC_SP_WAIT_EN: begin
          if (spinup_ev) begin
            st_q <= SPFC_SP_SPIN;
            imm_wait_q <= 1'b0;
          end else if (imm_wait_q && time_q >= 16'(ENABLE_TICKS)) begin
            st_q <= SPFC_SP_WAIT_START;
            imm_wait_q <= 1'b0;
          end
        end
        SPFC_SP_SPIN: begin
          if (spin_done_q || time_q >= 16'(READY_TICKS + EXTRA_TICKS)) begin
            st_q <= SPFC_SP_READY;
          end
        end
        SPFC_SP_READY: begin
          if (ss.valid && !ss.start) begin
            st_q <= SPFC_SP_STOP;
          end
        end
        SPFC_SP_STOP: begin
          if (stop_done_q || time_q >= 16'(STOP_TICKS)) begin
            st_q <= SPFC_SP_WAIT_START;
          end
        end
      endcase
    end
  end

  assign ev_ready = (st_q == SPFC_SP_SPIN) &&
                    (spin_done_q || time_q >= 16'(READY_TICKS + EXTRA_TICKS));
  assign ev_fail = (st_q == SPFC_SP_WAIT_EN) && !spinup_ev && imm_wait_q &&
                   time_q >= 16'(ENABLE_TICKS);
  assign ev_stopped = (st_q == SPFC_SP_STOP) && (stop_done_q || time_q >= 16'(STOP_TICKS));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_ready <= 1'b0;
      spindle_on <= 1'b0;
    end else begin
      unit_ready <= (st_q == SPFC_SP_READY);
      spindle_on <= (st_q == SPFC_SP_SPIN) || (st_q == SPFC_SP_READY);
    end
  end

  // ****************************************************************
  // format and block size
  // ****************************************************************
  logic [15:0] blk_act_q, blk_pend_q;
  logic fmt_busy_q;
  logic [1:0] fast_format_field;
  logic fmt_cmd, blk_ok, mult8, ev_fmt_err, ev_fmt_done;
  logic [23:0] sense_q;
  assign fmt_cmd = wr_en && paddr == OFF_CMD && pwdata[CMD_FMT] && cmd_accept;
  assign fast_format_field = pwdata[9:8];
  assign blk_ok = ctrl_native_q ? (blk_pend_q == BLK_4096 || blk_pend_q == BLK_4160)
                                : (blk_pend_q == BLK_512 || blk_pend_q == BLK_520);
  assign mult8 = (blk_pend_q == blk_act_q) ||
                 ({blk_act_q[12:0], 3'h0} == blk_pend_q) ||
                 ({blk_pend_q[12:0], 3'h0} == blk_act_q);
  assign ev_fmt_err = fmt_cmd && (fast_format_field[1] || !blk_ok || (fast_format_field == FAST_FORMAT_FIELD_FAST && !mult8));
  assign ev_fmt_done = fmt_busy_q && wr_en && paddr == OFF_CMD && pwdata[CMD_FMT_DONE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_act_q <= BLK_RESET;
      blk_pend_q <= BLK_RESET;
      fmt_busy_q <= 1'b0;
      sense_q <= 24'h0;
    end else begin
      if (wr_en && paddr == OFF_BLK) begin
        blk_pend_q <= pwdata[15:0];
      end
      if (ev_fmt_err) begin
        sense_q <= fast_format_field[1] ? {SENSE_KEY_ILL, SENSE_ASC_CDB, FAST_FORMAT_FIELD_PTR_BYTE[4:0], FAST_FORMAT_FIELD_PTR_BIT}
                           : {SENSE_KEY_ILL, SENSE_ASC_CDB, 8'h0};
      end else if (fmt_cmd) begin
        fmt_busy_q <= 1'b1;
        sense_q <= 24'h0;
      end
      if (ev_fmt_done) begin
        fmt_busy_q <= 1'b0;
        blk_act_q <= blk_pend_q;
      end
    end
  end

  // ****************************************************************
  // cache page bits
  // ****************************************************************
  logic read_ahead_disable_q, rcd_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_ahead_disable_q <= 1'b0;
      rcd_q <= 1'b0;
    end else if (wr_en && paddr == OFF_CACHE) begin
      read_ahead_disable_q <= pwdata[CACHE_DRA_BIT];
      rcd_q <= pwdata[CACHE_RCD_BIT];
    end
  end
  assign prefetch_en = ~read_ahead_disable_q;
  assign cache_en = ~rcd_q;

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [IRQ_W-1:0] irq_st_q, irq_msk_q, irq_set;
  assign irq_set = {ev_fmt_done, ev_fmt_err, ev_stopped, ev_fail, ev_ready};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
      irq_msk_q <= '0;
    end else begin
      if (wr_en && paddr == OFF_IRQ_MSK) begin
        irq_msk_q <= pwdata[IRQ_W-1:0];
      end
      if (wr_en && paddr == OFF_IRQ_ST) begin
        irq_st_q <= (irq_st_q & ~pwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
    end
  end
  assign irq = |(irq_st_q & irq_msk_q);

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite) begin
      unique case (paddr)
        OFF_CTRL: prdata = {31'h0, ctrl_native_q};
        OFF_STAT: prdata = {24'h0, fmt_busy_q, stop_first_q, seen_en_q, cmd_accept,
                            1'b0, st_q};
        OFF_CMD: prdata = 32'h0;
        OFF_FMT: prdata = {16'h0, time_q};
        OFF_BLK: prdata = {blk_act_q, blk_pend_q};
        OFF_CACHE: prdata = {26'h0, read_ahead_disable_q, 4'h0, rcd_q};
        OFF_IRQ_ST: prdata = {27'h0, irq_st_q};
        OFF_IRQ_MSK: prdata = {27'h0, irq_msk_q};
        OFF_SENSE: prdata = {8'h0, sense_q};
        default: prdata = 32'h0;
      endcase
    end
  end

endmodule // spfc_ctrl

`default_nettype wire

// ### core/spfc_pkg.sv
// Purpose: shared constants and types for the spin-up and fast format control block
// Assumes: 200 MHz pclk, APB register access
// Notes: one aligned 32-bit word per register
package spfc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned READY_LIMIT_S = 30;
  localparam int unsigned ENABLE_WAIT_S = 5;
  localparam int unsigned STOP_LIMIT_S = 23;
  localparam int unsigned ACCEPT_LIMIT_S = 3;
  localparam int unsigned EXTRA_READY_S = 5;
  localparam int unsigned READY_TICKS = READY_LIMIT_S * TICK_HZ;
  localparam int unsigned ENABLE_TICKS = ENABLE_WAIT_S * TICK_HZ;
  localparam int unsigned STOP_TICKS = STOP_LIMIT_S * TICK_HZ;
  localparam int unsigned ACCEPT_TICKS = ACCEPT_LIMIT_S * TICK_HZ;
  localparam int unsigned EXTRA_TICKS = EXTRA_READY_S * TICK_HZ;
  localparam int unsigned FMT_EXTRA_MIN = 30;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_CMD = 12'h008;
  localparam logic [11:0] OFF_FMT = 12'h00c;
  localparam logic [11:0] OFF_BLK = 12'h010;
  localparam logic [11:0] OFF_CACHE = 12'h014;
  localparam logic [11:0] OFF_IRQ_ST = 12'h018;
  localparam logic [11:0] OFF_IRQ_MSK = 12'h01c;
  localparam logic [11:0] OFF_SENSE = 12'h020;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int unsigned CMD_SS = 0;
  localparam int unsigned CMD_START = 1;
  localparam int unsigned CMD_IMMEDIATE_RETURN_FLAG = 2;
  localparam int unsigned CMD_FMT = 3;
  localparam int unsigned CMD_FMT_DONE = 4;
  localparam int unsigned CMD_FULL = 5;
  localparam int unsigned CTRL_NATIVE = 0;
  localparam int unsigned CTRL_SPIN_DONE = 1;
  localparam int unsigned CTRL_STOP_DONE = 2;
  localparam int unsigned CACHE_DRA_BIT = 5;
  localparam int unsigned CACHE_RCD_BIT = 0;
  localparam logic [1:0] FAST_FORMAT_FIELD_NONE = 2'h0;
  localparam logic [1:0] FAST_FORMAT_FIELD_FAST = 2'h1;
  localparam logic [7:0] SENSE_KEY_ILL = 8'h05;
  localparam logic [7:0] SENSE_ASC_CDB = 8'h24;
  localparam logic [7:0] FAST_FORMAT_FIELD_PTR_BYTE = 8'h04;
  localparam logic [2:0] FAST_FORMAT_FIELD_PTR_BIT = 3'h1;
  localparam logic [15:0] BLK_512 = 16'h0200;
  localparam logic [15:0] BLK_520 = 16'h0208;
  localparam logic [15:0] BLK_4096 = 16'h1000;
  localparam logic [15:0] BLK_4160 = 16'h1040;
  localparam logic [15:0] BLK_RESET = BLK_512;

  // interrupt bits
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_SS_FAIL = 1;
  localparam int unsigned IRQ_STOPPED = 2;
  localparam int unsigned IRQ_FMT_ERR = 3;
  localparam int unsigned IRQ_FMT_DONE = 4;
  localparam int unsigned IRQ_W = 5;

  typedef enum logic [2:0] {
    SPFC_SP_IDLE, SPFC_SP_WAIT_START, SPFC_SP_WAIT_EN, SPFC_SP_SPIN,
    SPFC_SP_READY, SPFC_SP_STOP
  } spfc_spin_e;

  typedef struct packed {
    logic valid;
    logic start;
    logic immediate_return_flag;
  } spfc_ss_s;

endpackage : spfc_pkg

// ### verification/spfc_ctrl_sva.sv
// Purpose: concurrent checks on the ports of the spin-up and format control block
// Assumes: single pclk domain, presetn asynchronous active low
// Notes: bound to every spfc_ctrl instance
`timescale 1ns/10ps
`default_nettype none

module spfc_ctrl_sva
  import spfc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device side
  input wire logic spinup_port0,
  input wire logic spinup_port1,
  input wire logic unit_ready,
  input wire logic cmd_accept,
  input wire logic spindle_on,
  input wire logic prefetch_en,
  input wire logic cache_en,
  input wire logic irq
);
  // ****************************************************************
  // helper state
  // ****************************************************************
  logic [15:0] cyc_q;
  logic seen_q;
  logic wr_cache;

  assign wr_cache = psel && penable && pwrite && (paddr == OFF_CACHE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc_q <= 16'h0000;
    else if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_q <= 1'b0;
    else if (spinup_port0 || spinup_port1) seen_q <= 1'b1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_prefetch;
    wr_cache |=> prefetch_en == !$past(pwdata[CACHE_DRA_BIT]);
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch enable not from write");

  property p_cache;
    wr_cache |=> cache_en == !$past(pwdata[CACHE_RCD_BIT]);
  endproperty
  a_cache: assert property (p_cache) else $error("cache enable not from write");

  property p_cache_hold;
    !wr_cache |=> $stable(prefetch_en) && $stable(cache_en);
  endproperty
  a_cache_hold: assert property (p_cache_hold) else $error("cache bits moved");

  property p_pready;
    psel && penable |-> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("access phase without ready");

  property p_slverr_phase;
    pslverr |-> psel && penable;
  endproperty
  a_slverr_phase: assert property (p_slverr_phase) else $error("error outside access phase");

  property p_unmapped;
    psel && penable && (paddr > OFF_SENSE) |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_accept_early;
    cyc_q < 16'd50000 |-> !cmd_accept;
  endproperty
  a_accept_early: assert property (p_accept_early) else $error("commands accepted too early");

  property p_spin_cause;
    $rose(spindle_on) |-> seen_q;
  endproperty
  a_spin_cause: assert property (p_spin_cause) else $error("spin-up without primitive");

  property p_ready_spin;
    unit_ready |-> spindle_on;
  endproperty
  a_ready_spin: assert property (p_ready_spin) else $error("ready with spindle off");

  property p_ready_rise;
    $rose(unit_ready) |-> $past(spindle_on) && !$past(unit_ready, 2);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready not after spin phase");

  c_spin: cover property ($rose(spindle_on));
  c_ready: cover property ($rose(unit_ready));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule // spfc_ctrl_sva

bind spfc_ctrl spfc_ctrl_sva spfc_ctrl_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .spinup_port0(spinup_port0),
  .spinup_port1(spinup_port1), .unit_ready(unit_ready), .cmd_accept(cmd_accept),
  .spindle_on(spindle_on), .prefetch_en(prefetch_en), .cache_en(cache_en), .irq(irq));

`default_nettype wire

// ### verification/spfc_host_model.sv
// Purpose: link-side partner sending enable-spinup primitives
// Assumes: primitive lines idle low between primitives
// Notes: pulses are driven by non-blocking assignment after a rising edge
`timescale 1ns/10ps
`default_nettype none

module spfc_host_model (
  // clock
  input wire logic pclk,
  // primitive lines
  output logic spinup_port0,
  output logic spinup_port1
);
  initial begin
    spinup_port0 = 1'b0;
    spinup_port1 = 1'b0;
  end

  task automatic pulse(input int port, input int len);
    @(posedge pclk);
    if (port == 0) spinup_port0 <= 1'b1;
    else spinup_port1 <= 1'b1;
    repeat (len) @(posedge pclk);
    spinup_port0 <= 1'b0;
    spinup_port1 <= 1'b0;
  endtask
endmodule // spfc_host_model

`default_nettype wire

// ### verification/testbench.sv
// Purpose: self-checking bench for the spin-up and format control block
// Assumes: 200 MHz pclk, zero-wait apb slave
// Notes: a shortened timing tick lets the command register open within the run
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import spfc_pkg::*;
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, got, exp); end end

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sp0, sp1, unit_ready, cmd_accept, spindle_on;
  logic prefetch_en, cache_en, irq, er;
  logic [31:0] rd, w;
  int miscompares = 0;
  int compares = 0;
  int port, n;

  always #2.5 pclk = ~pclk;

  spfc_host_model spfc_host_model_i (.pclk(pclk), .spinup_port0(sp0), .spinup_port1(sp1));

  spfc_ctrl #(.TICK_CYCLES(20)) spfc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spinup_port0(sp0), .spinup_port1(sp1), .unit_ready(unit_ready),
    .cmd_accept(cmd_accept), .spindle_on(spindle_on), .prefetch_en(prefetch_en),
    .cache_en(cache_en), .irq(irq));

  // ****************************************************************
  // expectations and bus cycles
  // ****************************************************************
  function automatic logic [1:0] exp_cache(input logic [31:0] v);
    return {~v[CACHE_DRA_BIT], ~v[CACHE_RCD_BIT]};
  endfunction

  function automatic logic [31:0] exp_blk(input logic [15:0] act, input logic [15:0] pend);
    return {act, pend};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(5 * 100000);
    miscompares++;
    give_verdict;
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    rd = $urandom(91613);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({prefetch_en, cache_en, unit_ready, spindle_on, cmd_accept}, 5'b11000)
    apb(1'b0, OFF_BLK, 32'h0);
    `CHK(rd, exp_blk(BLK_RESET, BLK_RESET))
    apb(1'b0, OFF_STAT, 32'h0);
    `CHK(rd[7:0], 8'h00)
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 32'h21 : ($urandom & 32'h21);
      apb(1'b1, OFF_CACHE, w);
      @(posedge pclk);
      `CHK({prefetch_en, cache_en}, exp_cache(w))
      apb(1'b0, OFF_CACHE, 32'h0);
      `CHK(rd & 32'h21, w)
    end
    apb(1'b1, OFF_BLK, {16'h0, BLK_520});
    apb(1'b1, OFF_CMD, 32'h10);
    apb(1'b0, OFF_BLK, 32'h0);
    `CHK(rd, exp_blk(BLK_512, BLK_520))
    apb(1'b1, OFF_CMD, 32'h0208);
    apb(1'b0, OFF_SENSE, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, 12'h040, 32'hffffffff);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h040, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, OFF_IRQ_MSK, 32'h0);
    port = $urandom_range(1, 0);
    spfc_host_model_i.pulse(port, 3);
    n = 0;
    while (spindle_on !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    `CHK({spindle_on, unit_ready}, 2'b10)
    apb(1'b0, OFF_STAT, 32'h0);
    `CHK({rd[5], rd[2:0]}, 4'hb)
    apb(1'b1, OFF_CTRL, 32'h2);
    n = 0;
    while (unit_ready !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    spfc_host_model_i.pulse(1 - port, 3);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFF_STAT, 32'h0);
    `CHK({unit_ready, rd[2:0]}, 4'hc)
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    `CHK({rd[IRQ_READY], irq}, 2'b10)
    apb(1'b1, OFF_IRQ_MSK, 32'h1 << IRQ_READY);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, OFF_IRQ_ST, 32'h1 << IRQ_READY);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    // format commands need the command register open
    while (cmd_accept !== 1'b1) @(posedge pclk);
    w = 32'h8 | ($urandom_range(3, 2) << 8);
    apb(1'b1, OFF_CMD, w);
    apb(1'b0, OFF_SENSE, 32'h0);
    `CHK(rd, 32'h00052421)
    apb(1'b1, OFF_CMD, 32'h108);
    apb(1'b0, OFF_SENSE, 32'h0);
    `CHK(rd, 32'h00052400)
    apb(1'b1, OFF_CMD, 32'h8);
    apb(1'b0, OFF_BLK, 32'h0);
    `CHK(rd, exp_blk(BLK_512, BLK_520))
    apb(1'b1, OFF_CMD, 32'h10);
    apb(1'b0, OFF_BLK, 32'h0);
    `CHK(rd, exp_blk(BLK_520, BLK_520))
    apb(1'b1, OFF_CTRL, 32'h1);
    // descriptor carries the new block length
    apb(1'b1, OFF_BLK, {16'h0, BLK_4160});
    // format with fast format value one
    apb(1'b1, OFF_CMD, 32'h108);
    apb(1'b0, OFF_SENSE, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, OFF_CMD, 32'h10);
    apb(1'b0, OFF_BLK, 32'h0);
    `CHK(rd, exp_blk(BLK_4160, BLK_4160))
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    `CHK(rd[IRQ_FMT_DONE:IRQ_FMT_ERR], 2'b11)
    // clean stop, then start with immediate and a primitive
    apb(1'b1, OFF_CMD, 32'h1);
    apb(1'b0, OFF_STAT, 32'h0);
    `CHK({spindle_on, rd[2:0]}, 4'h5)
    apb(1'b1, OFF_CTRL, 32'h5);
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    `CHK(rd[IRQ_STOPPED], 1'b1)
    apb(1'b1, OFF_CMD, 32'h7);
    spfc_host_model_i.pulse(port, 3);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_STAT, 32'h0);
    `CHK({rd[6], rd[2:0]}, 4'h3)
    give_verdict;
  end
endmodule // testbench

`default_nettype wire
